// File: verilog/asp_dev_end.sv
`timescale 1ns/1ps
module asp_fifo #(
  parameter int unsigned WIDTH = 8,
  parameter int unsigned DEPTH = 4
) (
  input  wire logic             i_sys_clk,
  input  wire logic             i_nrst,
  input  wire logic             i_in_valid,
  input  wire logic [WIDTH-1:0] i_in_data,
  output logic                  o_in_ready,
  output logic                  o_out_valid,
  output logic [WIDTH-1:0]      o_out_data,
  input  wire logic             i_out_ready
);
  localparam int unsigned AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;
  localparam int unsigned CW = $clog2(DEPTH + 1);

  logic [WIDTH-1:0] mem_reg [DEPTH];
  logic [AW-1:0]    wr_reg;
  logic [AW-1:0]    wr_next;
  logic [AW-1:0]    rd_reg;
  logic [AW-1:0]    rd_next;
  logic [CW-1:0]    cnt_reg;
  logic [CW-1:0]    cnt_next;
  logic             push;
  logic             pop;

  always_comb begin
    push     = i_in_valid && o_in_ready;
    pop      = o_out_valid && i_out_ready;
    wr_next  = wr_reg;
    rd_next  = rd_reg;
    cnt_next = cnt_reg;
    if (push) begin
      wr_next = (wr_reg == AW'(DEPTH - 1)) ? '0 : wr_reg + 1'b1;
    end
    if (pop) begin
      rd_next = (rd_reg == AW'(DEPTH - 1)) ? '0 : rd_reg + 1'b1;
    end
    if (push && !pop) begin
      cnt_next = cnt_reg + 1'b1;
    end else if (pop && !push) begin
      cnt_next = cnt_reg - 1'b1;
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      wr_reg      <= '0;
      rd_reg      <= '0;
      cnt_reg     <= '0;
      o_in_ready  <= 1'b0;
      o_out_valid <= 1'b0;
    end else begin
      wr_reg      <= wr_next;
      rd_reg      <= rd_next;
      cnt_reg     <= cnt_next;
      o_in_ready  <= (cnt_next != CW'(DEPTH));
      o_out_valid <= (cnt_next != '0);
    end
  end

  // Storage needs no reset; the count guards every read
  always_ff @(posedge i_sys_clk) begin
    if (push) begin
      mem_reg[wr_reg] <= i_in_data;
    end
  end

  assign o_out_data = mem_reg[rd_reg];
endmodule : asp_fifo

module asp_tx (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_nrst,
  input  wire logic [asp_pkg::DIV_W-1:0]   i_div,
  input  wire logic                        i_two_stop,
  input  wire logic                        i_valid,
  input  wire logic [7:0]                  i_data,
  output logic                             o_ready,
  output logic                             o_line
);
  typedef enum logic [1:0] {
    TX_IDLE  = 2'b00,
    TX_START = 2'b01,
    TX_DATA  = 2'b10,
    TX_STOP  = 2'b11
  } asp_tx_st_t;

  asp_tx_st_t                st_reg;
  asp_tx_st_t                st_next;
  logic [asp_pkg::DIV_W-1:0] cnt_reg;
  logic [asp_pkg::DIV_W-1:0] cnt_next;
  logic [2:0]                bit_reg;
  logic [2:0]                bit_next;
  logic [7:0]                sh_reg;
  logic [7:0]                sh_next;
  logic                      stop_reg;
  logic                      stop_next;
  logic                      line_next;
  logic                      ready_next;

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    stop_next  = stop_reg;
    line_next  = o_line;
    ready_next = o_ready;
    unique case (st_reg)
      TX_IDLE: begin
        line_next = asp_pkg::LINE_IDLE;
        if (i_valid && o_ready) begin
          sh_next    = i_data;
          cnt_next   = i_div - 1'b1;
          line_next  = asp_pkg::LINE_START;
          ready_next = 1'b0;
          st_next    = TX_START;
        end
      end
      TX_START: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          cnt_next  = i_div - 1'b1;
          bit_next  = '0;
          line_next = sh_reg[0];
          st_next   = TX_DATA;
        end
      end
      TX_DATA: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          cnt_next = i_div - 1'b1;
          sh_next  = sh_reg >> 1;
          if (bit_reg == 3'(asp_pkg::DATA_BITS - 1)) begin
            line_next = asp_pkg::LINE_IDLE;
            stop_next = i_two_stop;
            st_next   = TX_STOP;
          end else begin
            bit_next  = bit_reg + 1'b1;
            line_next = sh_reg[1];
          end
        end
      end
      TX_STOP: begin
        cnt_next = cnt_reg - 1'b1;
        if (cnt_reg == '0) begin
          // Next byte is refused until the whole stop minimum has elapsed
          if (stop_reg) begin
            stop_next = 1'b0;
            cnt_next  = i_div - 1'b1;
          end else begin
            ready_next = 1'b1;
            st_next    = TX_IDLE;
          end
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      st_reg   <= TX_IDLE;
      cnt_reg  <= '0;
      bit_reg  <= '0;
      sh_reg   <= '0;
      stop_reg <= 1'b0;
      o_line   <= 1'b1;
      o_ready  <= 1'b1;
    end else begin
      st_reg   <= st_next;
      cnt_reg  <= cnt_next;
      bit_reg  <= bit_next;
      sh_reg   <= sh_next;
      stop_reg <= stop_next;
      o_line   <= line_next;
      o_ready  <= ready_next;
    end
  end
endmodule : asp_tx

module asp_dev_end #(
  parameter logic FAST_OK = 1'b1
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  asp_link_if.dev         link,
  input  wire logic [3:0] i_rate_sel,
  input  wire logic       i_two_stop,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_frame_err,
  output logic            o_rate_err
);
  logic [asp_pkg::DIV_W-1:0] div_reg;
  logic [asp_pkg::DIV_W-1:0] div_next;
  logic                      rate_err_next;
  logic                      q_valid;
  logic [7:0]                q_data;
  logic                      ser_ready;
  logic [3:0]                sel_ok;

  // Rate changes apply at once; change only while the link is quiet
  always_comb begin
    sel_ok        = asp_pkg::legal_rate(i_rate_sel, FAST_OK);
    div_next      = asp_pkg::bit_cycles(sel_ok);
    rate_err_next = (sel_ok != i_rate_sel);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_reg    <= '1;
      o_rate_err <= 1'b0;
    end else begin
      div_reg    <= div_next;
      o_rate_err <= rate_err_next;
    end
  end

  asp_fifo #(.WIDTH(8), .DEPTH(asp_pkg::FIFO_DEPTH)) u_fifo (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_in_valid  (i_tx_valid),
    .i_in_data   (i_tx_data),
    .o_in_ready  (o_tx_ready),
    .o_out_valid (q_valid),
    .o_out_data  (q_data),
    .i_out_ready (ser_ready)
  );

  asp_tx u_tx (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_div      (div_reg),
    .i_two_stop (i_two_stop),
    .i_valid    (q_valid),
    .i_data     (q_data),
    .o_ready    (ser_ready),
    .o_line     (link.dev_to_host)
  );

  asp_rx u_rx (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_div       (div_reg),
    .i_line      (link.host_to_dev),
    .o_valid     (o_rx_valid),
    .o_data      (o_rx_data),
    .o_frame_err (o_frame_err)
  );
endmodule : asp_dev_end

// File: verilog/asp_pkg.sv
// Operation
// - Start bit precedes every byte, arms capture
// - Eight data bits, least significant first
// - No parity, one stop, ten bit frame; i_two_stop can add a second stop, eleven bits
// - Stop period lasts at least configured minimum
// - Idle gaps of any length are tolerated
// - Receiver accepts start after shortened stop
// - Receiver idles after byte, realigns on start
// - Rates selectable from 1200 to 921600 bps
// - Rates divided from clock, run slightly fast
// - Keep combined rate mismatch within 5 percent
package asp_pkg;

  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned DIV_W      = 16;
  localparam int unsigned DATA_BITS  = 8;
  localparam int unsigned FRAME_BITS = 10;
  localparam int unsigned NUM_RATES  = 11;
  localparam logic [3:0]  RATE_TOP   = 4'ha;
  localparam logic [3:0]  RATE_FALLBACK = 4'h9;
  localparam logic        LINE_IDLE  = 1'b1;
  localparam logic        LINE_START = 1'b0;
  localparam int unsigned FIFO_DEPTH = 4;
  localparam int unsigned MISMATCH_PCT_MAX = 5;

  localparam int unsigned RATE_TAB [NUM_RATES] = '{
    1200, 2400, 4800, 9600, 19200, 38400, 57600, 115200, 230400, 460800, 921600};

  // Integer division truncates, so every real rate sits slightly above nominal
  function automatic logic [DIV_W-1:0] bit_cycles(input logic [3:0] sel);
    bit_cycles = DIV_W'(CLK_HZ / RATE_TAB[sel]);
  endfunction : bit_cycles

  // Out of range or unsupported codes fall back to RATE_FALLBACK, one below the top rate, instead of misbehaving
  function automatic logic [3:0] legal_rate(input logic [3:0] sel, input logic fast_ok);
    if (sel > RATE_TOP || (sel == RATE_TOP && !fast_ok)) begin
      legal_rate = RATE_FALLBACK;
    end else begin
      legal_rate = sel;
    end
  endfunction : legal_rate

endpackage : asp_pkg

// File: verilog/asp_link_if.sv
`timescale 1ns/1ps
interface asp_link_if;
  logic dev_to_host;
  logic host_to_dev;

  modport dev (
    output dev_to_host,
    input  host_to_dev
  );

  modport host (
    output host_to_dev,
    input  dev_to_host
  );
endinterface : asp_link_if

// File: verilog/asp_host_end.sv
`timescale 1ns/1ps
module asp_host_end #(
  parameter logic FAST_OK = 1'b1
) (
  input  wire logic       i_sys_clk,
  input  wire logic       i_nrst,
  asp_link_if.host        link,
  input  wire logic [3:0] i_rate_sel,
  input  wire logic       i_two_stop,
  input  wire logic       i_tx_valid,
  input  wire logic [7:0] i_tx_data,
  output logic            o_tx_ready,
  output logic            o_rx_valid,
  output logic [7:0]      o_rx_data,
  output logic            o_frame_err,
  output logic            o_rate_err
);
  logic [asp_pkg::DIV_W-1:0] div_reg;
  logic [asp_pkg::DIV_W-1:0] div_next;
  logic                      rate_err_next;
  logic [3:0]                sel_ok;

  always_comb begin
    sel_ok        = asp_pkg::legal_rate(i_rate_sel, FAST_OK);
    div_next      = asp_pkg::bit_cycles(sel_ok);
    rate_err_next = (sel_ok != i_rate_sel);
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      div_reg    <= '1;
      o_rate_err <= 1'b0;
    end else begin
      div_reg    <= div_next;
      o_rate_err <= rate_err_next;
    end
  end

  // Same framing engines as the device end; unbuffered here
  asp_tx u_tx (
    .i_sys_clk  (i_sys_clk),
    .i_nrst     (i_nrst),
    .i_div      (div_reg),
    .i_two_stop (i_two_stop),
    .i_valid    (i_tx_valid),
    .i_data     (i_tx_data),
    .o_ready    (o_tx_ready),
    .o_line     (link.host_to_dev)
  );

  asp_rx u_rx (
    .i_sys_clk   (i_sys_clk),
    .i_nrst      (i_nrst),
    .i_div       (div_reg),
    .i_line      (link.dev_to_host),
    .o_valid     (o_rx_valid),
    .o_data      (o_rx_data),
    .o_frame_err (o_frame_err)
  );
endmodule : asp_host_end

module asp_rx (
  input  wire logic                        i_sys_clk,
  input  wire logic                        i_nrst,
  input  wire logic [asp_pkg::DIV_W-1:0]   i_div,
  input  wire logic                        i_line,
  output logic                             o_valid,
  output logic [7:0]                       o_data,
  output logic                             o_frame_err
);
  typedef enum logic [1:0] {
    RX_IDLE  = 2'b00,
    RX_START = 2'b01,
    RX_DATA  = 2'b10,
    RX_STOP  = 2'b11
  } asp_rx_st_t;

  asp_rx_st_t                st_reg;
  asp_rx_st_t                st_next;
  logic                      sync1_reg;
  logic                      sync2_reg;
  logic [asp_pkg::DIV_W-1:0] cnt_reg;
  logic [asp_pkg::DIV_W-1:0] cnt_next;
  logic [2:0]                bit_reg;
  logic [2:0]                bit_next;
  logic [7:0]                sh_reg;
  logic [7:0]                sh_next;
  logic                      valid_next;
  logic [7:0]                data_next;
  logic                      ferr_next;

  always_comb begin
    st_next    = st_reg;
    cnt_next   = cnt_reg - 1'b1;
    bit_next   = bit_reg;
    sh_next    = sh_reg;
    valid_next = 1'b0;
    data_next  = o_data;
    ferr_next  = 1'b0;
    unique case (st_reg)
      RX_IDLE: begin
        cnt_next = i_div >> 1;
        if (sync2_reg == asp_pkg::LINE_START) begin
          st_next = RX_START;
        end
      end
      RX_START: begin
        if (cnt_reg == '0) begin
          // Glitches shorter than half a bit are dropped here
          cnt_next = i_div - 1'b1;
          bit_next = '0;
          st_next  = (sync2_reg == asp_pkg::LINE_START) ? RX_DATA : RX_IDLE;
        end
      end
      RX_DATA: begin
        if (cnt_reg == '0) begin
          cnt_next = i_div - 1'b1;
          sh_next  = {sync2_reg, sh_reg[7:1]};
          bit_next = bit_reg + 1'b1;
          if (bit_reg == 3'(asp_pkg::DATA_BITS - 1)) begin
            st_next = RX_STOP;
          end
        end
      end
      RX_STOP: begin
        if (cnt_reg == '0) begin
          // Back to idle at mid stop, so an early start is caught
          if (sync2_reg == asp_pkg::LINE_IDLE) begin
            valid_next = 1'b1;
            data_next  = sh_reg;
          end else begin
            ferr_next = 1'b1;
          end
          st_next = RX_IDLE;
        end
      end
    endcase
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      sync1_reg   <= 1'b1;
      sync2_reg   <= 1'b1;
      st_reg      <= RX_IDLE;
      cnt_reg     <= '0;
      bit_reg     <= '0;
      sh_reg      <= '0;
      o_valid     <= 1'b0;
      o_data      <= '0;
      o_frame_err <= 1'b0;
    end else begin
      sync1_reg   <= i_line;
      sync2_reg   <= sync1_reg;
      st_reg      <= st_next;
      cnt_reg     <= cnt_next;
      bit_reg     <= bit_next;
      sh_reg      <= sh_next;
      o_valid     <= valid_next;
      o_data      <= data_next;
      o_frame_err <= ferr_next;
    end
  end
endmodule : asp_rx

// File: verif/asp_link_chk.sv
`timescale 1ns/1ps
module asp_link_chk (
  input wire logic       i_sys_clk,
  input wire logic       i_nrst,
  input wire logic [3:0] i_rate_sel,
  input wire logic       i_dev_to_host,
  input wire logic       i_host_to_dev
);
  logic [1:0]  ln;
  logic [1:0]  act_reg;
  logic [1:0]  act_next;
  int unsigned cnt_reg [2];
  int unsigned cnt_next [2];
  int unsigned bit_n;

  // Bit 0 watches dev_to_host, bit 1 host_to_dev
  assign ln = {i_host_to_dev, i_dev_to_host};
  // Out of range codes run at the fallback rate
  assign bit_n = asp_pkg::CLK_HZ /
    asp_pkg::RATE_TAB[(i_rate_sel > asp_pkg::RATE_TOP) ? asp_pkg::RATE_FALLBACK : i_rate_sel];

  // Frame tracker: sample 0 is the first low seen while idle
  always_comb begin
    for (int g = 0; g < 2; g++) begin
      act_next[g] = act_reg[g];
      cnt_next[g] = cnt_reg[g] + 1;
      if (!act_reg[g] && !ln[g]) begin
        act_next[g] = 1'b1;
        cnt_next[g] = 1;
      end else if (act_reg[g] && cnt_reg[g] >= asp_pkg::FRAME_BITS * bit_n - 1) begin
        act_next[g] = 1'b0;
      end
    end
  end

  always_ff @(posedge i_sys_clk or negedge i_nrst) begin
    if (!i_nrst) begin
      act_reg <= 2'h0;
      cnt_reg <= '{0, 0};
    end else begin
      act_reg <= act_next;
      cnt_reg <= cnt_next;
    end
  end

  default clocking cb @(posedge i_sys_clk);
  endclocking
  default disable iff (!i_nrst);

  sequence start_edge_s(int g);
    !act_reg[g] && $past(ln[g]) && !ln[g];
  endsequence
  sequence low_run_s(int g);
    !ln[g] [*8];
  endsequence

  property start_p(int g);
    act_reg[g] && cnt_reg[g] < bit_n |-> !ln[g];
  endproperty
  property stop_p(int g);
    act_reg[g] && cnt_reg[g] >= (asp_pkg::FRAME_BITS - 1) * bit_n |-> ln[g];
  endproperty
  // A level may only move on a bit boundary
  property bits_p(int g);
    act_reg[g] && cnt_reg[g] > bit_n && cnt_reg[g] < (asp_pkg::FRAME_BITS - 1) * bit_n &&
      cnt_reg[g] % bit_n != 0 |-> $stable(ln[g]);
  endproperty
  property hold_p(int g);
    start_edge_s(g) |-> low_run_s(g);
  endproperty

  h2d_start_a: assert property (start_p(1)) else $error("start bit short");
  d2h_start_a: assert property (start_p(0)) else $error("start bit short");
  h2d_stop_a: assert property (stop_p(1)) else $error("stop bit low");
  d2h_stop_a: assert property (stop_p(0)) else $error("stop bit low");
  h2d_bits_a: assert property (bits_p(1)) else $error("data bit unstable");
  d2h_bits_a: assert property (bits_p(0)) else $error("data bit unstable");
  h2d_hold_a: assert property (hold_p(1)) else $error("start glitch");
  d2h_hold_a: assert property (hold_p(0)) else $error("start glitch");
  reset_idle_a: assert property ($rose(i_nrst) |-> ln == 2'h3) else $error("not idle");
endmodule : asp_link_chk

// File: verif/async_serial_8n1_port_tb_top.sv
`timescale 1ns/1ps
module async_serial_8n1_port_tb_top;
  logic       i_sys_clk;
  logic       i_nrst;
  logic [3:0] rsel;
  logic       ts [2];
  logic       tv [2];
  logic [7:0] td [2];
  logic       tr [2];
  logic       re [3];
  logic       rxv [3];
  logic [7:0] rxd [3];
  logic       fe [3];
  logic [7:0] q [3][$];
  int         fe_cnt [3];
  int         bad_count;
  int         checked;
  int         bn;
  logic       stalled;

  asp_link_if link ();
  asp_link_if link_f ();
  asp_dev_end asp_dev_end_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link),
    .i_rate_sel(rsel), .i_two_stop(ts[0]), .i_tx_valid(tv[0]), .i_tx_data(td[0]),
    .o_tx_ready(tr[0]), .o_rx_valid(rxv[0]), .o_rx_data(rxd[0]), .o_frame_err(fe[0]),
    .o_rate_err(re[0]));
  asp_host_end asp_host_end_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .link(link),
    .i_rate_sel(rsel), .i_two_stop(ts[1]), .i_tx_valid(tv[1]), .i_tx_data(td[1]),
    .o_tx_ready(tr[1]), .o_rx_valid(rxv[1]), .o_rx_data(rxd[1]), .o_frame_err(fe[1]),
    .o_rate_err(re[1]));
  // Receiver facing a hand-driven line that breaks framing; port without the top rate
  asp_dev_end #(.FAST_OK(1'b0)) asp_dev_end_fault_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst),
    .link(link_f), .i_rate_sel(rsel), .i_two_stop(1'b0), .i_tx_valid(1'b0),
    .i_tx_data(8'h00), .o_tx_ready(), .o_rx_valid(rxv[2]), .o_rx_data(rxd[2]),
    .o_frame_err(fe[2]), .o_rate_err(re[2]));
  asp_link_chk asp_link_chk_i (.i_sys_clk(i_sys_clk), .i_nrst(i_nrst), .i_rate_sel(rsel),
    .i_dev_to_host(link.dev_to_host), .i_host_to_dev(link.host_to_dev));

  initial begin
    i_sys_clk = 1'b0;
    forever #50 i_sys_clk = ~i_sys_clk;
  end

  // Pulses are taken at the falling edge, where they have settled
  always @(negedge i_sys_clk) begin
    for (int k = 0; k < 3; k++) begin
      if (rxv[k] === 1'b1) q[k].push_back(rxd[k]);
      if (fe[k] === 1'b1) fe_cnt[k]++;
    end
  end

  task automatic chk(input logic ok, input string m);
    checked++;
    if (ok !== 1'b1) begin
      bad_count++;
      $display("BAD %0t %s", $time, m);
    end
  endtask : chk

  task automatic push(input int s, input logic [7:0] d);
    int n;
    n = 0;
    @(posedge i_sys_clk);
    #1;
    tv[s] = 1'b1;
    td[s] = d;
    while (tr[s] !== 1'b1 && n < 20000) begin
      stalled = 1'b1;
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    @(posedge i_sys_clk);
    #1;
    tv[s] = 1'b0;
  endtask : push

  task automatic expect_rx(input int k, input logic [7:0] d);
    int n;
    n = 0;
    while (q[k].size() == 0 && n < 12 * bn + 50) begin
      @(posedge i_sys_clk);
      n++;
    end
    #1;
    chk(q[k].size() > 0 && q[k][0] === d, "rx byte");
    if (q[k].size() > 0) void'(q[k].pop_front());
  endtask : expect_rx

  // Samples the host line at bit centres, counted from the start edge
  task automatic wire_chk(input logic [7:0] d, input logic two);
    int n;
    n = 0;
    while (link.host_to_dev !== 1'b0 && n < 5000) begin
      @(posedge i_sys_clk);
      #1;
      n++;
    end
    repeat (bn / 2) @(posedge i_sys_clk);
    chk(link.host_to_dev === 1'b0, "start level");
    for (int k = 0; k < 8; k++) begin
      repeat (bn) @(posedge i_sys_clk);
      chk(link.host_to_dev === d[k], "bit order");
    end
    repeat (bn) @(posedge i_sys_clk);
    chk(link.host_to_dev === 1'b1, "stop level");
    if (two) repeat (bn) @(posedge i_sys_clk);
    chk(link.host_to_dev === 1'b1, "second stop");
    #1;
  endtask : wire_chk

  task automatic t_basic();
    ts[1] = 1'b1;
    fork
      begin push(1, 8'ha5); push(1, 8'h3c); end
      begin wire_chk(8'ha5, 1'b1); wire_chk(8'h3c, 1'b1); end
      push(0, 8'h5e);
    join
    expect_rx(0, 8'ha5);
    expect_rx(0, 8'h3c);
    expect_rx(1, 8'h5e);
    $display("basic done");
  endtask : t_basic

  task automatic t_fifo();
    stalled = 1'b0;
    ts[0] = 1'b1;
    for (int i = 0; i < 6; i++) push(0, 8'h40 + 8'(i));
    chk(stalled, "fifo never full");
    for (int i = 0; i < 6; i++) expect_rx(1, 8'h40 + 8'(i));
    // First stop must finish before any later rate change
    repeat (bn) @(posedge i_sys_clk);
    #1;
    chk(tr[0] === 1'b1, "fifo not drained");
    $display("fifo done");
  endtask : t_fifo

  task automatic t_rates();
    for (int c = 0; c < 16; c++) begin
      rsel = 4'(c);
      bn = asp_pkg::CLK_HZ / asp_pkg::RATE_TAB[(c > 10) ? 9 : c];
      repeat (3) @(posedge i_sys_clk);
      #1;
      chk(re[0] === (c > 10) && re[1] === (c > 10), "rate flag");
      chk(re[2] === (c >= 10), "top rate flag");
      // Slowest codes only checked for the flag to keep the run short
      if (c >= 3 && (c <= 10 || c == 15)) begin
        fork
          push(1, 8'h11 * 8'(c));
          push(0, ~(8'h11 * 8'(c)));
        join
        expect_rx(0, 8'h11 * 8'(c));
        expect_rx(1, ~(8'h11 * 8'(c)));
        // Let the first stop bit run out before the rate moves
        repeat (bn) @(posedge i_sys_clk);
        #1;
      end
    end
    chk(fe_cnt[0] == 0 && fe_cnt[1] == 0, "false framing error");
    rsel = 4'h7;
    bn = asp_pkg::CLK_HZ / asp_pkg::RATE_TAB[7];
    $display("rates done");
  endtask : t_rates

  task automatic hold(input logic v, input int c);
    link_f.host_to_dev = v;
    repeat (c) @(posedge i_sys_clk);
    #1;
  endtask : hold

  task automatic raw(input logic [7:0] d, input int bl, input int sl, input logic sv);
    hold(1'b0, bl);
    for (int k = 0; k < 8; k++) hold(d[k], bl);
    hold(sv, sl);
  endtask : raw

  task automatic t_fault();
    repeat (3) @(posedge i_sys_clk);
    #1;
    raw(8'h5a, bn, bn, 1'b0);
    hold(1'b1, 40 * bn);
    chk(fe_cnt[2] == 1 && q[2].size() == 0, "framing");
    raw(8'h81, bn, bn, 1'b1);
    expect_rx(2, 8'h81);
    raw(8'hc3, bn, bn * 6 / 10, 1'b1);
    raw(8'h3c, bn, bn, 1'b1);
    expect_rx(2, 8'hc3);
    expect_rx(2, 8'h3c);
    raw(8'h96, bn * (100 + asp_pkg::MISMATCH_PCT_MAX - 1) / 100, bn, 1'b1);
    expect_rx(2, 8'h96);
    raw(8'h69, bn * (100 - asp_pkg::MISMATCH_PCT_MAX + 1) / 100, bn, 1'b1);
    expect_rx(2, 8'h69);
    $display("fault done");
  endtask : t_fault

  task automatic complete_run();
    $display("checked %0d bad_count %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0) begin
      $display("TEST PASSED");
    end else begin
      $display("TEST FAILED");
    end
    $finish;
  endtask : complete_run

  initial begin
    i_nrst = 1'b0;
    rsel = 4'h7;
    bn = asp_pkg::CLK_HZ / asp_pkg::RATE_TAB[7];
    ts = '{1'b0, 1'b0};
    tv = '{1'b0, 1'b0};
    td = '{8'h00, 8'h00};
    stalled = 1'b0;
    link_f.host_to_dev = 1'b1;
    repeat (8) @(posedge i_sys_clk);
    #1;
    i_nrst = 1'b1;
    repeat (2) @(posedge i_sys_clk);
    #1;
    chk(tr[0] === 1'b1 && tr[1] === 1'b1, "ready after reset");
    t_basic();
    t_fifo();
    t_rates();
    t_fault();
    complete_run();
  end

  initial begin
    #(90_000 * 100);
    bad_count++;
    $display("BAD %0t watchdog", $time);
    complete_run();
  end
endmodule : async_serial_8n1_port_tb_top
